// ---- design/tpv_regs.svh ----
/*
  register offsets, reset values and timing counts of the ping and
  voltage control block; included by the package users, no logic here
*/
`ifndef TPV_REGS_SVH
`define TPV_REGS_SVH

// register byte offsets on the apb
`define TPV_CTRL_OFS     12'h000
`define TPV_STAT_OFS     12'h004
`define TPV_FREQ_OFS     12'h008
`define TPV_VCMD_OFS     12'h00c
`define TPV_FSTEP_OFS    12'h010
`define TPV_PIDO_OFS     12'h014
`define TPV_SSV_OFS      12'h018

// field positions
`define TPV_CTRL_RUN     0
`define TPV_CTRL_RETRY   1
`define TPV_STAT_SS      3
`define TPV_STAT_FAIL    4
`define TPV_STAT_PWR     5

// reset values
`define TPV_CTRL_RST     2'h2
`define TPV_FSTEP_RST    8'h05

// voltage in units of 0.5 mV: 6.5 V, 3 V, 12 V
`define TPV_V_PING       16'h32c8
`define TPV_V_MIN        16'h1770
`define TPV_V_MAX        16'h5dc0

// operating frequency in kHz
`define TPV_F_START      8'h8c
`define TPV_F_MIN        8'h69

// pid: gain per mV, output limit, scaling magnitude in 0.5 mV units (negative)
`define TPV_PID_KP       4'h1
`define TPV_PID_LIM      16'h05dc
`define TPV_SV_STEPS     4'h1

// timing
`define TPV_CLK_MHZ         250
`define TPV_PING_WINDOW_US  70000
`define TPV_GAP_US          10000
`define TPV_PING_WINDOW_CYC (`TPV_PING_WINDOW_US * `TPV_CLK_MHZ)
`define TPV_GAP_CYC         (`TPV_GAP_US * `TPV_CLK_MHZ)

`endif

// ---- design/tpv_pkg.sv ----
/*
  types shared by the ping and voltage control block
  assumes nothing of its surroundings
*/
`default_nettype none

package tpv_pkg;

    typedef enum logic [1:0]
    {
        st_idle  = 2'b00,
        st_ping  = 2'b01,
        st_gap   = 2'b10,
        st_power = 2'b11
    } tpv_state_t;

endpackage

`default_nettype wire

// ---- design/tpv_pid.sv ----
/*
  one proportional step of the voltage loop: error from coil amplitude and
  control error, clamp, scale onto the voltage command, saturate the command
  assumes start is a one-cycle pulse on pclk with stable operands
*/
`timescale 1ns/1ps
`default_nettype none
`include "tpv_regs.svh"

module tpv_pid
    import tpv_pkg::*;
#(
    parameter int VW = 16
)(
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // request
    input  wire logic               start,
    input  wire logic signed [7:0]  ce,
    input  wire logic [15:0]        amp_mv,
    input  wire logic [VW-1:0]      v_old,
    // result
    output logic [VW-1:0]           v_new,
    output logic signed [15:0]      pid_out,
    output logic                    done
);

    if (VW < 15 || VW > 26)
    begin : g_chk
        $error("tpv_pid: VW must lie in 15..26");
    end

    function automatic logic signed [26:0] sat27(input logic signed [26:0] x,
                                                 input logic signed [26:0] lo,
                                                 input logic signed [26:0] hi);
        sat27 = (x < lo) ? lo : ((x > hi) ? hi : x);
    endfunction

    wire logic signed [26:0] lim   = $signed(27'(`TPV_PID_LIM));
    wire logic signed [26:0] vmin  = $signed(27'(`TPV_V_MIN));
    wire logic signed [26:0] vmax  = $signed(27'(`TPV_V_MAX));
    // RULE8 millivolt amplitude times ce over 128 is the error
    wire logic signed [26:0] prod  = $signed(27'({1'b0, amp_mv})) * 27'(ce);
    wire logic signed [26:0] err   = prod >>> 7;
    // RULE9 gain and clamp
    wire logic signed [26:0] p_raw = err * $signed(27'(`TPV_PID_KP));
    wire logic signed [26:0] p_lim = sat27(p_raw, -lim, lim);
    // RULE6 RULE7 voltage controlled, one half-millivolt count per unit
    wire logic signed [26:0] v_raw = $signed(27'(v_old))
                                     - p_lim * $signed(27'(`TPV_SV_STEPS));
    // RULE5 RULE10 command saturated to range
    wire logic signed [26:0] v_sat = sat27(v_raw, vmin, vmax);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            v_new   <= '0;
            pid_out <= '0;
            done    <= 1'b0;
        end
        else
        begin
            done <= start;
            if (start)
            begin
                v_new   <= v_sat[VW-1:0];
                pid_out <= p_lim[15:0];
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // RULE6 one count is half a millivolt
    step_fine_a: assert property (start && p_lim == 27'sh1 && v_raw > vmin && v_raw < vmax
        |=> $signed(27'(v_new)) == $signed(27'($past(v_old))) - 27'sh1) // RULE6
        else $error("voltage step not 0.5 mV");
    // RULE8 one millivolt of amplitude is resolved
    amp_resol_a: assert property (start && amp_mv == 16'h0080 && ce == 8'sh01
        |=> pid_out == 16'sh0001) // RULE8
        else $error("coil amplitude not resolved to 1 mV");
    // RULE9 output limit
    pid_limit_a: assert property (done |-> pid_out <= 16'sh05dc && pid_out >= -16'sh05dc) // RULE9
        else $error("pid output exceeds limit");
    // RULE10 command range
    vnew_range_a: assert property (done |-> v_new >= VW'(`TPV_V_MIN)
        && v_new <= VW'(`TPV_V_MAX)) // RULE10
        else $error("new voltage command out of range");

endmodule

`default_nettype wire

// ---- design/tpv_ctrl.sv ----
/*
  ping sequencer and voltage loop of a full-bridge transmitter, apb slave
  assumes packet decoder and coil amplitude sense run on pclk
*/
// Overview of operation
// RULE1 - first power signal of a ping commands 6.5 V inverter input
// RULE2 - first power signal uses 140 kHz operating frequency
// RULE3 - no signal strength packet in the window removes the power signal
// RULE4 - retries go to strictly lower frequencies, never under 105 kHz
// RULE5 - commanded inverter input stays inside 3 V to 12 V
// RULE6 - voltage command moves in steps finer than 50 mV
// RULE7 - power control is a pid loop on inverter input voltage
// RULE8 - coil voltage amplitude enters the loop with 1 mV resolution
// RULE9 - gain 1, no integral or derivative, limit 1500, scale -0.5 mV
// RULE10 - each new command is saturated to the voltage range
`timescale 1ns/1ps
`default_nettype none
`include "tpv_regs.svh"

module tpv_ctrl
    import tpv_pkg::*;
#(
    parameter int unsigned PING_WINDOW_CYC = `TPV_PING_WINDOW_CYC,
    parameter int unsigned GAP_CYC         = `TPV_GAP_CYC
)(
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // packet decoder
    input  wire logic               ss_valid,
    input  wire logic [7:0]         ss_value,
    input  wire logic               ce_valid,
    input  wire logic signed [7:0]  ce_value,
    // coil voltage sense
    input  wire logic [15:0]        coil_amp_mv,
    // inverter drive
    output logic                    power_on,
    output logic [15:0]             vin_cmd,
    output logic [7:0]              operating_frequency
);

    if (PING_WINDOW_CYC < 1 || GAP_CYC < 1)
    begin : g_chk
        $error("tpv_ctrl: window and gap counts must be at least 1");
    end

    tpv_state_t         state_reg, state_next;
    logic [31:0]        cnt_reg, cnt_next;
    logic               power_reg, power_next;
    logic [7:0]         freq_reg, freq_next;
    logic [15:0]        v_reg, v_next;
    logic               fail_set;
    logic [1:0]         ctrl_reg;
    logic [7:0]         fstep_reg;
    logic [7:0]         ssv_reg;
    logic signed [15:0] pido_reg;
    logic               ss_seen_reg;
    logic               fail_reg;
    logic [31:0]        prdata_reg;
    logic               pready_reg;
    logic               pslverr_reg;
    logic [15:0]        pid_v;
    logic signed [15:0] pid_out;
    logic               pid_done;

    // bus decode
    wire logic setup    = psel & ~penable;
    wire logic wr       = psel & penable & pready_reg & pwrite;
    wire logic wr_ctrl  = wr && paddr == `TPV_CTRL_OFS;
    wire logic wr_stat  = wr && paddr == `TPV_STAT_OFS;
    wire logic wr_fstep = wr && paddr == `TPV_FSTEP_OFS;
    wire logic hit      = paddr == `TPV_CTRL_OFS || paddr == `TPV_STAT_OFS
                       || paddr == `TPV_FREQ_OFS || paddr == `TPV_VCMD_OFS
                       || paddr == `TPV_FSTEP_OFS || paddr == `TPV_PIDO_OFS
                       || paddr == `TPV_SSV_OFS;
    wire logic [31:0] rd_data =
        (paddr == `TPV_CTRL_OFS)  ? {30'h0, ctrl_reg} :
        (paddr == `TPV_STAT_OFS)  ? {26'h0, power_reg, fail_reg, ss_seen_reg, 1'b0, state_reg} :
        (paddr == `TPV_FREQ_OFS)  ? {24'h0, freq_reg} :
        (paddr == `TPV_VCMD_OFS)  ? {16'h0, v_reg} :
        (paddr == `TPV_FSTEP_OFS) ? {24'h0, fstep_reg} :
        (paddr == `TPV_PIDO_OFS)  ? {16'h0, pido_reg} :
        (paddr == `TPV_SSV_OFS)   ? {24'h0, ssv_reg} : 32'h0000_0000;

    // sequencer decode
    wire logic start_cmd = wr_ctrl & pwdata[`TPV_CTRL_RUN] & (state_reg == st_idle);
    wire logic stop_cmd  = wr_ctrl & ~pwdata[`TPV_CTRL_RUN];
    wire logic ss_hit    = (state_reg == st_ping) & ss_valid;
    wire logic ping_end  = (state_reg == st_ping) && !ss_valid
                        && cnt_reg == PING_WINDOW_CYC - 1;
    wire logic [8:0] f_dec = {1'b0, freq_reg} - {1'b0, fstep_reg};
    wire logic can_retry = ctrl_reg[`TPV_CTRL_RETRY] && fstep_reg != 8'h00
                        && !f_dec[8] && f_dec[7:0] >= `TPV_F_MIN;
    wire logic pid_start = (state_reg == st_power) & ce_valid & ~stop_cmd;

    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg + 32'h0000_0001;
        power_next = power_reg;
        freq_next  = freq_reg;
        v_next     = v_reg;
        fail_set   = 1'b0;
        if (stop_cmd)
        begin
            state_next = st_idle;
            power_next = 1'b0;
        end
        else
        begin
            case (state_reg)
                st_idle:
                begin
                    cnt_next = 32'h0000_0000;
                    // RULE1 RULE2 first ping values
                    if (start_cmd)
                    begin
                        state_next = st_ping;
                        power_next = 1'b1;
                        freq_next  = `TPV_F_START;
                        v_next     = `TPV_V_PING;
                    end
                end
                st_ping:
                begin
                    if (ss_valid)
                    begin
                        state_next = st_power;
                    end
                    // RULE3 remove power without packet
                    else if (ping_end)
                    begin
                        power_next = 1'b0;
                        cnt_next   = 32'h0000_0000;
                        // RULE4 retry lower frequency
                        if (can_retry)
                        begin
                            state_next = st_gap;
                            freq_next  = f_dec[7:0];
                        end
                        else
                        begin
                            state_next = st_idle;
                            fail_set   = 1'b1;
                        end
                    end
                end
                st_gap:
                begin
                    if (cnt_reg == GAP_CYC - 1)
                    begin
                        state_next = st_ping;
                        power_next = 1'b1;
                        v_next     = `TPV_V_PING;
                        cnt_next   = 32'h0000_0000;
                    end
                end
                st_power:
                begin
                    // RULE7 loop result drives inverter input
                    if (pid_done)
                    begin
                        v_next = pid_v;
                    end
                end
                default:
                begin
                    state_next = st_idle;
                    power_next = 1'b0;
                end
            endcase
        end
    end

    tpv_pid #(
        .VW      (16)
    ) u_pid (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (pid_start),
        .ce      (ce_value),
        .amp_mv  (coil_amp_mv),
        .v_old   (v_reg),
        .v_new   (pid_v),
        .pid_out (pid_out),
        .done    (pid_done)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= st_idle;
            cnt_reg   <= 32'h0000_0000;
            power_reg <= 1'b0;
            freq_reg  <= `TPV_F_START;
            v_reg     <= `TPV_V_PING;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            power_reg <= power_next;
            freq_reg  <= freq_next;
            v_reg     <= v_next;
        end
    end

    // registers and bus answer; hardware set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg    <= `TPV_CTRL_RST;
            fstep_reg   <= `TPV_FSTEP_RST;
            ssv_reg     <= 8'h00;
            pido_reg    <= 16'sh0000;
            ss_seen_reg <= 1'b0;
            fail_reg    <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_reg <= pwdata[1:0];
            else if (fail_set)
                ctrl_reg[`TPV_CTRL_RUN] <= 1'b0;
            if (wr_fstep)
                fstep_reg <= pwdata[7:0];
            if (ss_hit)
                ssv_reg <= ss_value;
            if (pid_done)
                pido_reg <= pid_out;
            ss_seen_reg <= ss_hit | (ss_seen_reg & ~(wr_stat & pwdata[`TPV_STAT_SS]));
            fail_reg    <= fail_set | (fail_reg & ~(wr_stat & pwdata[`TPV_STAT_FAIL]));
            pready_reg  <= setup;
            pslverr_reg <= setup & ~hit;
            if (setup)
                prdata_reg <= hit ? rd_data : 32'h0000_0000;
        end
    end

    assign prdata              = prdata_reg;
    assign pready              = pready_reg;
    assign pslverr             = pslverr_reg;
    assign power_on            = power_reg;
    assign vin_cmd             = v_reg;
    assign operating_frequency = freq_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // RULE1 ping voltage
    ping_volt_a: assert property ($rose(power_reg) |-> v_reg == `TPV_V_PING) // RULE1
        else $error("power applied without 6.5 V command");
    // RULE2 first frequency
    ping_freq_a: assert property ($rose(power_reg) && $past(state_reg) == st_idle
        |-> freq_reg == `TPV_F_START) // RULE2
        else $error("first ping not at 140 kHz");
    // RULE3 removal after window
    no_ss_off_a: assert property (ping_end |=> !power_reg && state_reg != st_power) // RULE3
        else $error("power kept without signal strength packet");
    // RULE4 lower retry frequency
    freq_down_a: assert property (ping_end && can_retry && !stop_cmd
        |=> state_reg == st_gap && freq_reg < $past(freq_reg)
            && freq_reg >= `TPV_F_MIN) // RULE4
        else $error("retry frequency not lower or below 105 kHz");
    // RULE5 voltage range
    volt_range_a: assert property (power_reg |-> v_reg >= `TPV_V_MIN
        && v_reg <= `TPV_V_MAX) // RULE5
        else $error("voltage command out of 3..12 V");
    // RULE7 loop drives voltage
    loop_apply_a: assert property (pid_start ##1 (pid_done && !stop_cmd
        && state_reg == st_power) |=> vin_cmd == $past(pid_v)) // RULE7
        else $error("pid result not applied to voltage command");

endmodule

`default_nettype wire

// ---- bench/tpv_rx_model.sv ----
/*
  behavioural power receiver on the far side of the coil
  assumes power_on from the block; bench sets presence and packet content
*/
`timescale 1ns/1ps
`default_nettype none

module tpv_rx_model
(
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // coil power
    input  wire logic               power_on,
    // bench control
    input  wire logic               present,
    input  wire logic [7:0]         ss_delay,
    input  wire logic [7:0]         ss_level,
    input  wire logic               ce_req,
    input  wire logic signed [7:0]  ce_in,
    input  wire logic [15:0]        amp_in,
    // packets
    output logic                    ss_valid,
    output logic [7:0]              ss_value,
    output logic                    ce_valid,
    output logic signed [7:0]       ce_value,
    output logic [15:0]             coil_amp_mv
);
    logic [7:0] on_reg;
    logic [7:0] junk_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            on_reg   <= 8'h00;
            junk_reg <= 8'h5a;
        end
        else
        begin
            junk_reg <= junk_reg + 8'h3b;
            on_reg   <= power_on ? (on_reg + {7'h00, ~&on_reg}) : 8'h00;
        end
    end

    // an unpowered receiver sends nothing; idle fields carry no stale value
    assign ss_valid    = present & power_on & (on_reg == ss_delay);
    assign ss_value    = ss_valid ? ss_level : junk_reg;
    assign ce_valid    = ce_req & power_on;
    assign ce_value    = ce_valid ? ce_in : $signed(~junk_reg);
    assign coil_amp_mv = amp_in;
endmodule

`default_nettype wire

// ---- bench/test_transmitter_ping_voltage_pid.sv ----
/*
  self-checking bench of the ping and voltage control block
  assumes tpv_ctrl with a short window and gap, receiver model on the far side
*/
`timescale 1ns/1ps
`default_nettype none
`include "tpv_regs.svh"

module test_transmitter_ping_voltage_pid;
    import tpv_pkg::*;
    localparam int W = 50;
    localparam int G = 10;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic ss_valid, ce_valid, power_on, present, ce_req, err;
    logic [7:0] ss_value, operating_frequency, ss_delay, ss_level;
    logic signed [7:0] ce_value, ce_in;
    logic [15:0] coil_amp_mv, amp_in, vin_cmd, v_model, last_p;
    int failures, check_count, cycles, n, k;
    integer seed;

    tpv_ctrl #(.PING_WINDOW_CYC(W), .GAP_CYC(G)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ss_valid(ss_valid),
        .ss_value(ss_value), .ce_valid(ce_valid), .ce_value(ce_value),
        .coil_amp_mv(coil_amp_mv), .power_on(power_on), .vin_cmd(vin_cmd),
        .operating_frequency(operating_frequency));

    tpv_rx_model rx (.pclk(pclk), .presetn(presetn), .power_on(power_on),
        .present(present), .ss_delay(ss_delay), .ss_level(ss_level), .ce_req(ce_req),
        .ce_in(ce_in), .amp_in(amp_in), .ss_valid(ss_valid), .ss_value(ss_value),
        .ce_valid(ce_valid), .ce_value(ce_value), .coil_amp_mv(coil_amp_mv));

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic end_of_test;
        $display("failures %0d checks %0d", failures, check_count);
        if (failures == 0 && check_count > 0)
        begin
            $display("TEST PASSED");
        end
        else
        begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            failures++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp, "read data");
        chk({31'h0, err}, {31'h0, e}, "slave error");
    endtask

    task automatic wait_pwr(input logic lvl, input int lim);
        // step off the edge so that a level launched there is seen
        #1;
        n = 0;
        while (power_on !== lvl && n < lim)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk({31'h0, power_on}, {31'h0, lvl}, "power level");
    endtask

    function automatic logic [15:0] next_v(input logic [15:0] v, input logic signed [7:0] c,
                                           input logic [15:0] a, output logic [15:0] p);
        longint e;
        longint nv;
        e = (longint'(a) * longint'(c)) >>> 7;
        e = (e > 1500) ? 1500 : ((e < -1500) ? -1500 : e);
        p = 16'(e);
        nv = longint'(v) - e;
        nv = (nv > 24000) ? 24000 : ((nv < 6000) ? 6000 : nv);
        return 16'(nv);
    endfunction

    task automatic ce_step(input logic signed [7:0] c, input logic [15:0] a);
        v_model = next_v(v_model, c, a, last_p);
        @(posedge pclk);
        ce_req <= 1'b1; ce_in <= c; amp_in <= a;
        @(posedge pclk);
        ce_req <= 1'b0;
        repeat (2) @(posedge pclk);
        #1 chk({16'h0, vin_cmd}, {16'h0, v_model}, "voltage command");
    endtask

    initial
    begin
        seed = 59; cycles = 0; failures = 0; check_count = 0;
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0000_0000; present = 1'b1;
        ss_delay = 8'hc8; ss_level = 8'h9e; ce_req = 1'b0; ce_in = 8'sh00;
        amp_in = 16'h0000;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`TPV_CTRL_OFS, 32'h0000_0002, 1'b0);
        rd_chk(`TPV_FSTEP_OFS, 32'h0000_0005, 1'b0);
        rd_chk(`TPV_FREQ_OFS, 32'h0000_008c, 1'b0);
        rd_chk(`TPV_VCMD_OFS, 32'h0000_32c8, 1'b0);
        rd_chk(12'h01c, 32'h0000_0000, 1'b1);
        // first window unanswered, answered after one retry
        apb(1'b1, `TPV_CTRL_OFS, 32'h0000_0003);
        wait_pwr(1'b1, 4);
        chk({16'h0, vin_cmd}, 32'h0000_32c8, "ping voltage");
        chk({24'h0, operating_frequency}, 32'h0000_008c, "ping frequency");
        wait_pwr(1'b0, W + 5);
        chk(n, W, "ping window");
        chk({24'h0, operating_frequency}, 32'h0000_0087, "retry frequency");
        ss_delay = 8'h07;
        wait_pwr(1'b1, G + 5);
        chk(n, G, "retry gap");
        chk({16'h0, vin_cmd}, 32'h0000_32c8, "retry voltage");
        repeat (12) @(posedge pclk);
        rd_chk(`TPV_STAT_OFS, 32'h0000_002b, 1'b0);
        rd_chk(`TPV_SSV_OFS, 32'h0000_009e, 1'b0);
        // loop driven to both ends of the voltage range, then at random
        v_model = 16'h32c8;
        repeat (10) ce_step(-8'sd128, 16'hffff);
        repeat (16) ce_step(8'sd127, 16'hffff);
        repeat (40) ce_step(8'($random(seed)), 16'($random(seed)) & 16'h1fff);
        ce_step(-8'sd128, 16'hffff);
        ce_step(8'sd3, 16'h0100);
        ce_step(8'sd1, 16'h0080);
        rd_chk(`TPV_PIDO_OFS, {16'h0, last_p}, 1'b0);
        apb(1'b1, `TPV_CTRL_OFS, 32'h0000_0002);
        wait_pwr(1'b0, 4);
        chk({31'h0, power_on}, 32'h0000_0000, "stop");
        // no receiver: 140 then 120 kHz, then give up above the floor
        present = 1'b0;
        apb(1'b1, `TPV_FSTEP_OFS, 32'h0000_0014);
        apb(1'b1, `TPV_CTRL_OFS, 32'h0000_0003);
        k = 0;
        n = 0;
        repeat (200)
        begin
            @(posedge pclk);
            #1;
            if (power_on === 1'b1 && n == 0)
            begin
                chk({24'h0, operating_frequency}, (k == 0) ? 32'h8c : 32'h78, "freq");
                chk({16'h0, vin_cmd}, 32'h0000_32c8, "retry voltage");
                k++;
            end
            n = (power_on === 1'b1) ? 1 : 0;
        end
        chk(k, 2, "attempts");
        rd_chk(`TPV_CTRL_OFS, 32'h0000_0002, 1'b0);
        rd_chk(`TPV_STAT_OFS, 32'h0000_0018, 1'b0);
        apb(1'b1, `TPV_STAT_OFS, 32'h0000_0018);
        rd_chk(`TPV_STAT_OFS, 32'h0000_0000, 1'b0);
        end_of_test();
    end
endmodule

`default_nettype wire
